// ===== logic/pcc_defs.svh
// constants for the pager address code converter
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

// ============================================================
// letter codes (ascii)
`define PCC_CH_A 8'h41
`define PCC_CH_E 8'h45
`define PCC_CH_I 8'h49
`define PCC_CH_L 8'h4C
`define PCC_CH_P 8'h50
`define PCC_CH_S 8'h53
`define PCC_CH_U 8'h55
`define PCC_CH_Y 8'h59
`define PCC_CH_Z 8'h5A

// ============================================================
// digit fields
`define PCC_BATT_MAX 4'h7
`define PCC_BATT_DEFAULT 3'h4
`define PCC_FRAME_MAX 10'h07F
`define PCC_DIGITS_SHORT 4'h7
`define PCC_DIGITS_LONG12 4'h9
`define PCC_DIGITS_LONG 4'hA

// ============================================================
// address value limits
`define PCC_ADDR_MIN 33'h0_0000_0001
`define PCC_ADDR_MAX 33'h1_4020_0FFE
`define PCC_SHORT_LIMIT 33'h0_001E_FFFF
`define PCC_LONG_FLOOR 33'h0_0020_1000
`define PCC_NINE_MAX 33'h0_3B9A_C9FF
`define PCC_SHORT_OFFSET 21'h00_8000
`define PCC_WORD_ZERO 21'h00_0000
`define PCC_WORD_ONES 21'h1F_FFFF

`endif

// ===== logic/pcc_pkg.sv
// types for the pager address code converter
package pcc_pkg;

  typedef enum logic [1:0] {
    PCC_DEV_SINGLE,
    PCC_DEV_ANY,
    PCC_DEV_ALL,
    PCC_DEV_NONE
  } pcc_dev_t;

  typedef enum logic [1:0] {
    PCC_CLS_SHORT,
    PCC_CLS_LONG12,
    PCC_CLS_LONG_OTHER,
    PCC_CLS_NONE
  } pcc_class_t;

  typedef struct packed {
    logic [7:0] typeLetter;
    logic hasRoam;
    logic [7:0] roamLetter;
    logic hasBattery;
    logic [3:0] batteryDigit;
    logic hasFrame;
    logic [9:0] frameValue;
    logic [3:0] digitCount;
    logic [32:0] address;
  } pcc_req_t;

  typedef struct packed {
    pcc_dev_t devType;
    logic standardForm;
    pcc_class_t addrClass;
    logic phaseKnown;
    logic [1:0] phase;
    logic frameBattKnown;
    logic [6:0] frame;
    logic [2:0] battery;
    logic wordValid;
    logic [20:0] word;
    logic shortestForm;
  } pcc_res_t;

endpackage

// ===== logic/pcc_type_decode.sv
// decodes the type letter of a pager address code
`timescale 1ns/1ps
`include "pcc_defs.svh"

module pcc_type_decode (
  input wire logic [7:0] letter,
  output pcc_pkg::pcc_dev_t devType,
  output logic letterOk,
  output logic standard,
  output logic [1:0] subtract,
  output logic phaseFixed,
  output logic [1:0] fixedPhase
);
  import pcc_pkg::*;

  logic [7:0] stdIdx;
  logic [7:0] nsIdx;

  assign stdIdx = letter - `PCC_CH_A;
  assign nsIdx = letter - `PCC_CH_U;

  always_comb begin
    devType = PCC_DEV_NONE;
    letterOk = 1'b0;
    standard = 1'b0;
    subtract = 2'h0;
    phaseFixed = 1'b0;
    fixedPhase = 2'h0;
    if (letter >= `PCC_CH_A && letter <= `PCC_CH_L) begin
      letterOk = 1'b1;
      standard = 1'b1;
      subtract = stdIdx[1:0];
      if (letter < `PCC_CH_E) begin
        devType = PCC_DEV_SINGLE;
      end else if (letter < `PCC_CH_I) begin
        devType = PCC_DEV_ANY;
      end else begin
        devType = PCC_DEV_ALL;
      end
    end else if (letter >= `PCC_CH_U && letter <= `PCC_CH_Z) begin
      letterOk = 1'b1;
      if (letter < `PCC_CH_Y) begin
        devType = PCC_DEV_SINGLE;
        phaseFixed = 1'b1;
        fixedPhase = nsIdx[1:0];
      end else if (letter == `PCC_CH_Y) begin
        devType = PCC_DEV_ANY;
      end else begin
        devType = PCC_DEV_ALL;
      end
    end
  end

endmodule

// ===== logic/pcc_converter.sv
// pager address code converter: fields in, assignment data and air word out
// Function
// R1: only type letters A to L and U to Z are valid; any other letter is an error.
// R2: letters A to L take an optional battery digit that must be 0 to 7.
// R3: a standard code without battery digit yields battery cycle 4.
// R4: letters U to Z take an optional frame 0 to 127 and battery digit, passed straight out.
// R5: a non-standard code without frame and battery marks them unknown.
// R6: a roaming prefix P to S is legal only ahead of a ten-digit address.
// R7: seven digits mean short, nine long set 1-2, ten the other long sets.
// R8: addresses run 1 to 5,370,810,366; short below 2,031,615, long above 2,101,248.
// R9: the shortest form is flagged, and a standard letter counts as the standard form.
// R10: standard types take phase from address bits 3:2 and frame from bits 10:4.
// R11: letters A to D subtract 0 to 3 from the address before extraction.
// R12: letters E to H and I to L subtract likewise and report any- and all-phase types.
// R13: letters U to X give single-phase with phase fixed at 0 to 3.
// R14: letter Y gives non-standard any-phase, Z non-standard all-phase, with no phase.
// R15: a short address plus 32,768 is output as the 21-bit air word.
// R16: an air word of all zeros or all ones is reported illegal.
// R17: any invalid field raises the error flag and suppresses results, one clock after input.
`timescale 1ns/1ps
`include "pcc_defs.svh"

module pcc_converter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic inValid,
  input pcc_pkg::pcc_req_t req,
  output logic outValid,
  output logic errFlag,
  output pcc_pkg::pcc_res_t res
);
  import pcc_pkg::*;

  // ============================================================
  // letter decode
  pcc_dev_t decDev;
  logic letterOk;
  logic standard;
  logic [1:0] subtract;
  logic phaseFixed;
  logic [1:0] fixedPhase;

  pcc_type_decode u_decode (
    .letter(req.typeLetter),
    .devType(decDev),
    .letterOk(letterOk),
    .standard(standard),
    .subtract(subtract),
    .phaseFixed(phaseFixed),
    .fixedPhase(fixedPhase)
  );

  // ============================================================
  // field checks and conversion
  logic [32:0] adjAddr;
  logic [20:0] shortWord;
  logic next_err;
  pcc_res_t next_res;

  assign adjAddr = req.address - {31'h0, subtract}; // R11 R12
  assign shortWord = req.address[20:0] + `PCC_SHORT_OFFSET; // R15

  always_comb begin
    next_err = 1'b0;
    next_res = '0;
    next_res.devType = decDev; // R12 R14
    next_res.standardForm = standard; // R9
    next_res.addrClass = PCC_CLS_NONE;
    if (!letterOk) begin
      next_err = 1'b1; // R1
    end
    if (req.hasRoam && (req.roamLetter < `PCC_CH_P || req.roamLetter > `PCC_CH_S
        || req.digitCount != `PCC_DIGITS_LONG)) begin
      next_err = 1'b1; // R6
    end
    if (req.address < `PCC_ADDR_MIN || req.address > `PCC_ADDR_MAX) begin
      next_err = 1'b1; // R8
    end
    case (req.digitCount)
      `PCC_DIGITS_SHORT: begin
        next_res.addrClass = PCC_CLS_SHORT; // R7
        if (req.address >= `PCC_SHORT_LIMIT) begin
          next_err = 1'b1; // R8
        end
        next_res.shortestForm = 1'b1; // R9
      end
      `PCC_DIGITS_LONG12: begin
        next_res.addrClass = PCC_CLS_LONG12; // R7
        if (req.address <= `PCC_LONG_FLOOR || req.address > `PCC_NINE_MAX) begin
          next_err = 1'b1; // R8
        end
        next_res.shortestForm = 1'b1; // R9
      end
      `PCC_DIGITS_LONG: begin
        next_res.addrClass = PCC_CLS_LONG_OTHER; // R7
        if (req.address <= `PCC_LONG_FLOOR) begin
          next_err = 1'b1; // R8
        end
        next_res.shortestForm = (req.address > `PCC_NINE_MAX); // R9
      end
      default: begin
        next_err = 1'b1; // R7
      end
    endcase
    if (standard) begin
      // a frame field has no meaning with the standard letters
      if (req.hasFrame || (req.hasBattery && req.batteryDigit > `PCC_BATT_MAX)) begin
        next_err = 1'b1; // R2
      end
      // underflow would wrap into a foreign frame, so reject it
      if (req.address < {31'h0, subtract}) begin
        next_err = 1'b1; // R11
      end
      next_res.battery = req.hasBattery ? req.batteryDigit[2:0] : `PCC_BATT_DEFAULT; // R2 R3
      next_res.frameBattKnown = 1'b1;
      next_res.frame = adjAddr[10:4]; // R10
      next_res.phase = adjAddr[3:2]; // R10
      next_res.phaseKnown = (decDev == PCC_DEV_SINGLE); // R10
    end else begin
      if (req.hasFrame != req.hasBattery) begin
        next_err = 1'b1; // R4
      end
      if (req.hasFrame && (req.frameValue > `PCC_FRAME_MAX || req.batteryDigit > `PCC_BATT_MAX)) begin
        next_err = 1'b1; // R4
      end
      next_res.frameBattKnown = req.hasFrame && req.hasBattery; // R5
      next_res.frame = req.hasFrame ? req.frameValue[6:0] : 7'h00; // R4
      next_res.battery = req.hasBattery ? req.batteryDigit[2:0] : 3'h0; // R4
      next_res.phaseKnown = phaseFixed; // R13 R14
      next_res.phase = fixedPhase; // R13
    end
    if (next_res.addrClass == PCC_CLS_SHORT) begin
      next_res.wordValid = 1'b1;
      next_res.word = shortWord; // R15
      if (shortWord == `PCC_WORD_ZERO || shortWord == `PCC_WORD_ONES) begin
        next_err = 1'b1; // R16
      end
    end
    if (next_err) begin
      next_res = '0; // R17
      next_res.devType = PCC_DEV_NONE;
      next_res.addrClass = PCC_CLS_NONE;
    end
  end

  // ============================================================
  // result registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      outValid <= 1'b0;
    end else if (clkEn) begin
      outValid <= inValid; // R17
    end
  end

  // results hold between requests so the host may read late
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      errFlag <= 1'b0;
      res <= '0;
    end else if (clkEn && inValid) begin
      errFlag <= next_err; // R17
      res <= next_res;
    end
  end

  // ============================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // marks the edge that carries a fresh answer; deliberately outside the enable,
  // a frozen marker would pair the checks with a stale request
  logic pastTake;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pastTake <= 1'b0;
    end else begin
      pastTake <= clkEn && inValid;
    end
  end

  property p_bad_letter;
    pastTake && !(($past(req.typeLetter) >= `PCC_CH_A && $past(req.typeLetter) <= `PCC_CH_L)
      || ($past(req.typeLetter) >= `PCC_CH_U && $past(req.typeLetter) <= `PCC_CH_Z)) |-> errFlag && outValid;
  endproperty
  a_bad_letter: assert property (p_bad_letter) else $error("bad letter not flagged"); // R1

  property p_batt_range;
    pastTake && $past(standard) && $past(req.hasBattery) && $past(req.batteryDigit) > 4'h7 |-> errFlag;
  endproperty
  a_batt_range: assert property (p_batt_range) else $error("battery digit above 7 accepted"); // R2

  property p_batt_default;
    pastTake && $past(standard) && !$past(req.hasBattery) && !errFlag |-> res.battery == 3'h4;
  endproperty
  a_batt_default: assert property (p_batt_default) else $error("default battery not 4"); // R3

  property p_frame_pass;
    pastTake && !$past(standard) && $past(req.hasFrame) && !errFlag
      |-> res.frame == $past(req.frameValue[6:0]) && res.battery == $past(req.batteryDigit[2:0]);
  endproperty
  a_frame_pass: assert property (p_frame_pass) else $error("frame or battery not passed"); // R4

  property p_unknown;
    pastTake && !$past(standard) && !$past(req.hasFrame) && !errFlag |-> !res.frameBattKnown;
  endproperty
  a_unknown: assert property (p_unknown) else $error("missing fields not marked unknown"); // R5

  property p_roam;
    pastTake && $past(req.hasRoam) && $past(req.digitCount) != 4'hA |-> errFlag;
  endproperty
  a_roam: assert property (p_roam) else $error("roaming code without ten digits accepted"); // R6

  property p_range;
    pastTake && $past(req.address) > 33'h1_4020_0FFE |-> errFlag;
  endproperty
  a_range: assert property (p_range) else $error("address above maximum accepted"); // R8

  property p_phase_extract;
    pastTake && $past(standard) && $past(decDev == PCC_DEV_SINGLE) && !errFlag
      |-> res.phase == $past(adjAddr[3:2]) && res.frame == $past(adjAddr[10:4]);
  endproperty
  a_phase_extract: assert property (p_phase_extract) else $error("phase or frame extraction wrong"); // R10

  property p_fixed_phase;
    pastTake && $past(req.typeLetter) == 8'h57 && !errFlag |-> res.phase == 2'h2 && res.phaseKnown;
  endproperty
  a_fixed_phase: assert property (p_fixed_phase) else $error("fixed phase for W wrong"); // R13

  property p_short_word;
    pastTake && $past(req.digitCount) == 4'h7 && !errFlag
      |-> res.wordValid && res.word == $past(req.address[20:0]) + 21'h00_8000;
  endproperty
  a_short_word: assert property (p_short_word) else $error("short air word wrong"); // R15

  property p_suppress;
    errFlag |-> !res.wordValid && !res.frameBattKnown && !res.phaseKnown;
  endproperty
  a_suppress: assert property (p_suppress) else $error("results shown with error"); // R17

  c_short_std: cover property (pastTake && !errFlag && res.standardForm && res.addrClass == PCC_CLS_SHORT);
  c_nonstd_unknown: cover property (pastTake && !errFlag && !res.standardForm && !res.frameBattKnown);
  c_long: cover property (pastTake && !errFlag && res.addrClass == PCC_CLS_LONG_OTHER);
  c_error: cover property (pastTake && errFlag);

endmodule

// ===== testbench/pcc_host_model.sv
// host side model that presents parsed address code fields
`timescale 1ns/1ps
module pcc_host_model (
  input wire logic ref_clk,
  input wire logic outValid,
  output logic inValid,
  output pcc_pkg::pcc_req_t req
);
  import pcc_pkg::*;

  initial begin
    inValid = 1'b0;
    req = '0;
  end

  // one strobe per request; fields stay put until the next request
  task automatic send(input pcc_req_t r, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge ref_clk);
    inValid <= 1'b1;
    req <= r;
    @(posedge ref_clk);
    inValid <= 1'b0;
    // bounded wait so a missing answer cannot hang the host
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge ref_clk);
      ok = (outValid === 1'b1);
      if (!ok) @(posedge ref_clk);
    end
  endtask
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the pager address code converter
`timescale 1ns/1ps
module testbench;
  import pcc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic inValid, outValid, errFlag, ok;
  pcc_req_t req;
  pcc_res_t res, bad;
  int badCount = 0;
  int checked = 0;

  always #20 ref_clk = ~ref_clk;

  pcc_host_model u_host (.ref_clk(ref_clk), .outValid(outValid), .inValid(inValid), .req(req));
  pcc_converter u_dut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .inValid(inValid), .req(req),
    .outValid(outValid), .errFlag(errFlag), .res(res));

  // ==========================================
  // helpers
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // fields that carry no meaning are not compared
  function automatic pcc_res_t msk(input pcc_res_t r);
    if (r.phaseKnown !== 1'b1) r.phase = '0;
    if (r.frameBattKnown !== 1'b1) begin
      r.frame = '0;
      r.battery = '0;
    end
    if (r.wordValid !== 1'b1) r.word = '0;
    return r;
  endfunction

  function automatic pcc_req_t mk(input int l, input int rm, input int b, input int f, input int d,
                                  input logic [32:0] a);
    pcc_req_t r;
    r = '0;
    r.typeLetter = 8'(l);
    r.hasRoam = (rm != 0);
    r.roamLetter = 8'(rm);
    r.hasBattery = (b >= 0);
    r.batteryDigit = (b < 0) ? 4'h0 : 4'(b);
    r.hasFrame = (f >= 0);
    r.frameValue = (f < 0) ? 10'h000 : 10'(f);
    r.digitCount = 4'(d);
    r.address = a;
    return r;
  endfunction

  function automatic pcc_res_t ex(input pcc_req_t q);
    pcc_res_t e;
    int i;
    logic [32:0] a;
    e = '0;
    e.standardForm = (q.typeLetter <= 8'h4C);
    e.addrClass = (q.digitCount == 4'h7) ? PCC_CLS_SHORT : (q.digitCount == 4'h9) ? PCC_CLS_LONG12 : PCC_CLS_LONG_OTHER;
    e.shortestForm = (q.digitCount != 4'hA) || (q.address > 33'h0_3B9A_C9FF);
    e.wordValid = (q.digitCount == 4'h7);
    e.word = 21'(q.address + 33'h0_0000_8000);
    if (e.standardForm) begin
      i = q.typeLetter - 8'h41;
      a = q.address - 33'(i % 4);
      e.devType = pcc_dev_t'(i / 4);
      e.phaseKnown = (i < 4);
      e.phase = a[3:2];
      e.frame = a[10:4];
      e.frameBattKnown = 1'b1;
      e.battery = q.hasBattery ? q.batteryDigit[2:0] : 3'h4;
    end else begin
      i = q.typeLetter - 8'h55;
      e.devType = (i < 4) ? PCC_DEV_SINGLE : (i == 4) ? PCC_DEV_ANY : PCC_DEV_ALL;
      e.phaseKnown = (i < 4);
      e.phase = 2'(i);
      e.frameBattKnown = q.hasFrame;
      e.frame = q.frameValue[6:0];
      e.battery = q.batteryDigit[2:0];
    end
    return msk(e);
  endfunction

  task automatic run(input pcc_req_t q, input logic err);
    u_host.send(q, ok);
    check(48'(ok), 48'h1);
    check(48'(errFlag), 48'(err));
    check(48'(msk(res)), 48'(err ? bad : ex(q)));
  endtask

  // ==========================================
  // scenarios
  task automatic t_std();
    for (int l = 8'h41; l <= 8'h4C; l++) begin
      run(mk(l, 0, -1, -1, 7, 33'h0_0012_D687 + 33'(l)), 1'b0);
      run(mk(l, 0, l % 8, -1, 9, 33'h0_075B_CD15 + 33'(l)), 1'b0);
    end
    $display("t_std done");
  endtask

  task automatic t_nonstd();
    for (int l = 8'h55; l <= 8'h5A; l++) begin
      run(mk(l, 0, 7, 127, 7, 33'h0_000F_4240 + 33'(l)), 1'b0);
      run(mk(l, 0, -1, -1, 10, 33'h1_0020_0FFE), 1'b0);
    end
    $display("t_nonstd done");
  endtask

  task automatic t_edges();
    for (int p = 8'h50; p <= 8'h53; p++) begin
      run(mk(8'h41, p, 0, -1, 10, 33'h0_7735_93FF + 33'(p)), 1'b0);
    end
    run(mk(8'h41, 0, -1, -1, 7, 33'h0_0000_0001), 1'b0);
    run(mk(8'h41, 0, -1, -1, 7, 33'h0_001E_FFFE), 1'b0);
    run(mk(8'h41, 0, -1, -1, 9, 33'h0_0020_1001), 1'b0);
    run(mk(8'h45, 0, -1, -1, 10, 33'h0_075B_CD15), 1'b0);
    run(mk(8'h49, 0, -1, -1, 10, 33'h1_4020_0FFE), 1'b0);
    $display("t_edges done");
  endtask

  task automatic t_err();
    pcc_req_t e[16];
    e = '{mk(8'h4D, 0, -1, -1, 7, 100), mk(8'h54, 0, -1, -1, 7, 100), mk(8'h41, 0, 8, -1, 7, 100),
          mk(8'h55, 0, 3, 128, 7, 100), mk(8'h55, 0, -1, 5, 7, 100), mk(8'h41, 0, 3, 5, 7, 100),
          mk(8'h41, 8'h54, -1, -1, 10, 33'h0_B2D0_5E00), mk(8'h41, 8'h52, -1, -1, 7, 100),
          mk(8'h41, 0, -1, -1, 8, 100), mk(8'h41, 0, -1, -1, 7, 0),
          mk(8'h41, 0, -1, -1, 7, 33'h0_001E_FFFF), mk(8'h41, 0, -1, -1, 9, 33'h0_0020_1000),
          mk(8'h41, 0, -1, -1, 10, 33'h1_4020_0FFF), mk(8'h44, 0, -1, -1, 7, 2),
          mk(8'h55, 0, -1, -1, 7, 33'h0_001F_7FFF), mk(8'h41, 0, -1, -1, 9, 33'h0_3B9A_CA00)};
    foreach (e[k]) begin
      run(e[k], 1'b1);
    end
    $display("t_err done");
  endtask

  // a request offered while the clock enable is low must leave the result alone
  task automatic t_freeze();
    pcc_res_t held;
    held = res;
    @(posedge ref_clk);
    clkEn <= 1'b0;
    u_host.send(mk(8'h45, 0, -1, -1, 7, 77), ok);
    check(48'(ok), 48'h0);
    check(48'(errFlag), 48'h1);
    check(48'(res), 48'(held));
    clkEn <= 1'b1;
    $display("t_freeze done");
  endtask

  // ==========================================
  // run control
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    bad = '0;
    bad.devType = PCC_DEV_NONE;
    bad.addrClass = PCC_CLS_NONE;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_std();
    t_nonstd();
    t_edges();
    t_err();
    t_freeze();
    give_verdict();
  end

  // about 60 requests of a few cycles each; far more than that means a hang
  initial begin
    #200000;
    badCount++;
    give_verdict();
  end
endmodule
